//--- src/tar_resolver.sv
// Receiver side telegram handling: commissioning parse, private address
// resolution, CCM signature check and replay rejection.
// Assumes an external AES-128 core answering aes_req with aes_ack.
// Behaviour
// RQ1 - Commissioning payload: counter, key, static address
// RQ2 - Vendor element: type 0xFF, manufacturer id
// RQ3 - Size byte covers address plus payload
// RQ4 - Commissioning length 0x1D, also accept 0x1E
// RQ5 - Frame ends with three check bytes
// RQ6 - Address upper half random, lower half hash
// RQ7 - Random part top bits must be 01
// RQ8 - AES identity key over zero padded random
// RQ9 - Low 24 result bits equal hash resolves
// RQ10 - Try every stored key until match
// RQ11 - Length field always two bytes
// RQ12 - Signature always four bytes
// RQ13 - Authenticated payload at most 13 bytes
// RQ14 - Source address enters little endian
// RQ15 - Input length 9, 10, 11 or 13
// RQ16 - Counter from input bytes 4 to 7
// RQ17 - Sender counter starts zero, increments
// RQ18 - Accept only counter above highest accepted
// RQ19 - Repeated copies share one counter
// RQ20 - Shared 16 byte security key
// RQ21 - Authentication covers address, counter, status, options
// RQ22 - CCM authentication with AES-128
// RQ23 - Nonce: address, counter, zero padding
// RQ24 - First block: flag 0x49, nonce, zeros
// RQ25 - Compare first four vector bytes only
// RQ26 - Bad signature: discard, keep counter
`timescale 1ns/1ps
module tar_resolver #(
  parameter logic [15:0] MFR_ID = 16'h5A5A  // Expected manufacturer id, arbitrary value
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic rx_valid,
  input wire logic rx_start,
  input wire logic [7:0] rx_byte,
  input wire logic learn_en,
  input wire logic [tar_pkg::KIDX_W-1:0] learn_slot,
  output logic learn_valid,
  output logic [31:0] learn_seq,
  output logic [127:0] learn_key,
  output logic [47:0] learn_addr,
  output logic aes_req,
  output logic [127:0] aes_key,
  output logic [127:0] aes_din,
  input wire logic aes_ack,
  input wire logic [127:0] aes_dout,
  output logic result_valid,
  output logic result_accept,
  output logic result_resolved,
  output logic [tar_pkg::KIDX_W-1:0] result_slot,
  output logic busy
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef struct packed {
    tar_pkg::tar_state_t state;          // Sequencer
    logic [tar_pkg::KIDX_W-1:0] idx;     // Key slot under test
    logic priv_addr;                     // Address is resolvable
    logic [47:0] addr;                   // Source address value
    logic [31:0] seq;                    // Received counter
    logic [31:0] sig;                    // Received signature
    logic [103:0] nonce;                 // CCM nonce
    logic [127:0] b1;                    // Length and input data block
    logic [127:0] blk;                   // Block handed to the cipher
    logic [127:0] s0;                    // Counter block result
    logic sig_ok;                        // Signature matched
    logic lrn_v;
    logic [31:0] lrn_seq;
    logic [127:0] lrn_key;
    logic [47:0] lrn_addr;
    logic res_v;
    logic res_acc;
    logic res_resolved;
  } tar_core_t;

  tar_core_t st;
  tar_core_t next_st;
  logic [tar_pkg::FRAME_MAX-1:0][7:0] fr;   // Collected frame
  logic fr_done;                            // Frame end pulse
  tar_pkg::tar_entry_t ent;                 // Slot under test
  logic mem_we;
  logic [tar_pkg::KIDX_W-1:0] mem_widx;
  tar_pkg::tar_entry_t mem_wdata;
  logic [7:0] plen;                         // Payload length byte
  logic [7:0] ilen;                         // Authenticated byte count
  logic hdr_ok;                             // Vendor element recognised
  logic is_comm;                            // Commissioning frame
  logic is_data;                            // Authenticated data frame
  logic [47:0] f_addr;
  logic [31:0] f_seq;
  logic [127:0] f_key;
  logic [47:0] f_saddr;
  logic [103:0] f_nonce;
  logic [127:0] f_b1;
  logic [31:0] f_sig;
  logic adv;                                // Move to next slot

  // ----------------------------------------------------------------
  // Leaf modules
  // ----------------------------------------------------------------
  tar_frame_parser u_parser (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .rx_valid(rx_valid),
    .rx_start(rx_start),
    .rx_byte(rx_byte),
    .frame(fr),
    .frame_done(fr_done)
  );

  // Read index held on the slot so the key stays steady for the cipher
  tar_key_mem u_keys (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .wr_en(mem_we),
    .wr_idx(mem_widx),
    .wr_data(mem_wdata),
    .rd_idx(st.idx),
    .rd_data(ent)
  );

  // ----------------------------------------------------------------
  // Frame field decode
  // ----------------------------------------------------------------
  // Only the accepted optional data sizes give a valid length
  function automatic logic ilen_legal(input logic [7:0] n);
    ilen_legal = (n == tar_pkg::ILEN0) || (n == tar_pkg::ILEN1) ||
                 (n == tar_pkg::ILEN2) || (n == tar_pkg::ILEN4);  // RQ13 RQ15
  endfunction

  always_comb
  begin
    plen = fr[tar_pkg::POS_PLEN];
    ilen = plen - tar_pkg::ILEN_OFF;
    hdr_ok = (fr[tar_pkg::POS_TYPE] == tar_pkg::TYPE_MFR) &&
             ({fr[tar_pkg::POS_MFR + 1], fr[tar_pkg::POS_MFR]} == MFR_ID);  // RQ2
    // Old units send 0x1E; the size byte still shows the true length
    is_comm = hdr_ok && (plen == tar_pkg::PLEN_COMM || plen == tar_pkg::PLEN_COMM_OLD) &&
              (fr[tar_pkg::POS_LEN] == 8'(tar_pkg::ADDR_BYTES + tar_pkg::PLEN_EXTRA) +
               tar_pkg::PLEN_COMM);  // RQ4 RQ3
    is_data = hdr_ok && ilen_legal(ilen) &&
              (fr[tar_pkg::POS_LEN] == 8'(tar_pkg::ADDR_BYTES + tar_pkg::PLEN_EXTRA) + plen);
    f_addr = '0;
    f_saddr = '0;
    for (int i = 0; i < tar_pkg::ADDR_BYTES; i++)
    begin
      f_addr[8*i +: 8] = fr[tar_pkg::POS_ADDR + i];
      f_saddr[8*i +: 8] = fr[tar_pkg::POS_SADDR + i];  // RQ1
    end
    f_seq = '0;
    for (int i = 0; i < tar_pkg::SEQ_BYTES; i++)
    begin
      f_seq[8*i +: 8] = fr[tar_pkg::POS_SEQ + i];  // RQ16 RQ1
    end
    f_key = '0;
    for (int i = 0; i < tar_pkg::KEY_BYTES; i++)
    begin
      f_key[127 - 8*i -: 8] = fr[tar_pkg::POS_KEY + i];  // RQ1 RQ20
    end
    // Nonce: address bytes as sent, counter bytes, zero pad
    f_nonce = '0;
    for (int i = 0; i < tar_pkg::ADDR_BYTES + tar_pkg::SEQ_BYTES; i++)
    begin
      f_nonce[103 - 8*i -: 8] = (i < tar_pkg::ADDR_BYTES) ? fr[tar_pkg::POS_ADDR + i] :
                                fr[tar_pkg::POS_SEQ + i - tar_pkg::ADDR_BYTES];  // RQ23 RQ14
    end
    // Second block: two byte length then input data, zero padded
    f_b1 = '0;
    f_b1[127:112] = {8'h00, ilen};  // RQ11
    for (int i = 0; i < tar_pkg::IDATA_MAX; i++)
    begin
      if (i < int'(ilen))
      begin
        f_b1[111 - 8*i -: 8] = fr[tar_pkg::POS_PLEN + i];  // RQ21
      end
    end
    f_sig = '0;
    for (int i = 0; i < tar_pkg::SIG_BYTES; i++)
    begin
      f_sig[31 - 8*i -: 8] = fr[(tar_pkg::POS_PLEN + i + int'(ilen)) % tar_pkg::FRAME_MAX];  // RQ12
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Frames finishing while busy are dropped; repeats carry the same counter
  always_comb
  begin
    next_st = st;
    next_st.lrn_v = 1'b0;
    next_st.res_v = 1'b0;
    adv = 1'b0;
    case (st.state)
      tar_pkg::S_IDLE:
      begin
        if (fr_done && is_comm)
        begin
          next_st.lrn_v = 1'b1;
          next_st.lrn_seq = f_seq;
          next_st.lrn_key = f_key;
          next_st.lrn_addr = f_saddr;
        end
        else if (fr_done && is_data)
        begin
          next_st.addr = f_addr;
          next_st.priv_addr = (f_addr[47:46] == tar_pkg::PRIV_MODE);  // RQ6 RQ7
          next_st.seq = f_seq;
          next_st.sig = f_sig;
          next_st.nonce = f_nonce;
          next_st.b1 = f_b1;
          next_st.idx = '0;
          next_st.state = tar_pkg::S_RD;
        end
      end
      // Registered slot data arrives one cycle after the index
      tar_pkg::S_RD:
      begin
        next_st.state = tar_pkg::S_MATCH;
      end
      tar_pkg::S_MATCH:
      begin
        if (!ent.valid)
        begin
          adv = 1'b1;
        end
        else if (st.priv_addr)
        begin
          next_st.blk = {104'h0, st.addr[47:24]};  // RQ8
          next_st.state = tar_pkg::S_HASH;
        end
        else if (ent.addr == st.addr)
        begin
          next_st.blk = {tar_pkg::CTR_BLOCK_FLAG, st.nonce, 16'h0000};
          next_st.state = tar_pkg::S_A0;
        end
        else
        begin
          adv = 1'b1;
        end
      end
      tar_pkg::S_HASH:
      begin
        if (aes_ack && aes_dout[23:0] == st.addr[23:0])
        begin
          next_st.blk = {tar_pkg::CTR_BLOCK_FLAG, st.nonce, 16'h0000};  // RQ9
          next_st.state = tar_pkg::S_A0;
        end
        else if (aes_ack)
        begin
          adv = 1'b1;  // RQ10
        end
      end
      tar_pkg::S_A0:
      begin
        if (aes_ack)
        begin
          next_st.s0 = aes_dout;
          next_st.blk = {tar_pkg::FIRST_BLOCK_FLAG, st.nonce, 16'h0000};  // RQ24 RQ22
          next_st.state = tar_pkg::S_X1;
        end
      end
      tar_pkg::S_X1:
      begin
        if (aes_ack)
        begin
          next_st.blk = aes_dout ^ st.b1;  // RQ22
          next_st.state = tar_pkg::S_X2;
        end
      end
      tar_pkg::S_X2:
      begin
        if (aes_ack)
        begin
          next_st.sig_ok = ((aes_dout[127:96] ^ st.s0[127:96]) == st.sig);  // RQ25 RQ12
          next_st.state = tar_pkg::S_CHECK;
        end
      end
      // Replay guard: strictly above the highest accepted counter
      tar_pkg::S_CHECK:
      begin
        next_st.res_v = 1'b1;
        next_st.res_resolved = 1'b1;
        next_st.res_acc = st.sig_ok && (st.seq > ent.seq);  // RQ18 RQ26
        next_st.state = tar_pkg::S_IDLE;
      end
      tar_pkg::S_DONE:
      begin
        next_st.res_v = 1'b1;
        next_st.res_resolved = 1'b0;
        next_st.res_acc = 1'b0;
        next_st.state = tar_pkg::S_IDLE;
      end
      default:
      begin
        next_st.state = tar_pkg::S_IDLE;
      end
    endcase
    // No slot left: report unresolved
    if (adv)
    begin
      next_st.state = (st.idx == tar_pkg::KIDX_W'(tar_pkg::NKEY - 1)) ?
                      tar_pkg::S_DONE : tar_pkg::S_RD;  // RQ10
      next_st.idx = st.idx + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '{state: tar_pkg::S_IDLE, default: '0};
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Key store writes and outputs
  // ----------------------------------------------------------------
  // Learning writes from idle; counter update only on a good signature
  always_comb
  begin
    mem_we = 1'b0;
    mem_widx = st.idx;
    mem_wdata = ent;
    if (st.state == tar_pkg::S_IDLE && fr_done && is_comm && learn_en)
    begin
      mem_we = 1'b1;
      mem_widx = learn_slot;
      mem_wdata = '{valid: 1'b1, key: f_key, addr: f_saddr, seq: f_seq};
    end
    else if (st.state == tar_pkg::S_CHECK && st.sig_ok && st.seq > ent.seq)
    begin
      mem_we = 1'b1;
      mem_wdata.seq = st.seq;  // RQ18 RQ26
    end
  end

  assign aes_req = (st.state == tar_pkg::S_HASH) || (st.state == tar_pkg::S_A0) ||
                   (st.state == tar_pkg::S_X1) || (st.state == tar_pkg::S_X2);
  assign aes_key = ent.key;
  assign aes_din = st.blk;
  assign learn_valid = st.lrn_v;
  assign learn_seq = st.lrn_seq;
  assign learn_key = st.lrn_key;
  assign learn_addr = st.lrn_addr;
  assign result_valid = st.res_v;
  assign result_accept = st.res_acc;
  assign result_resolved = st.res_resolved;
  assign result_slot = st.idx;
  assign busy = (st.state != tar_pkg::S_IDLE);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_comm_learn: assert property (!busy && fr_done && is_comm |=> learn_valid && // RQ1
    learn_seq == $past(f_seq) && learn_addr == $past(f_saddr))
    else $error("commissioning fields not reported");
  a_hash_input: assert property (st.state == tar_pkg::S_HASH |-> // RQ8
    aes_din == {104'h0, st.addr[47:24]} && st.addr[47:46] == 2'b01)
    else $error("hash block not padded random part");
  a_hash_miss: assert property (st.state == tar_pkg::S_HASH && aes_ack && // RQ9
    aes_dout[23:0] != st.addr[23:0] |=> st.state != tar_pkg::S_A0)
    else $error("mismatching hash resolved the address");
  a_first_block: assert property (st.state == tar_pkg::S_X1 |-> // RQ24
    aes_din[127:120] == 8'h49 && aes_din[15:0] == 16'h0000)
    else $error("first block flag wrong");
  a_len_field: assert property ($rose(st.state == tar_pkg::S_X2) |-> // RQ11
    aes_din[127:112] == ($past(aes_dout[127:112]) ^ {8'h00, st.b1[119:112]}))
    else $error("length field not two bytes");
  a_ilen_legal: assert property (st.state == tar_pkg::S_RD |-> // RQ15
    st.b1[119:112] inside {8'h09, 8'h0A, 8'h0B, 8'h0D})
    else $error("illegal input length processed");
  a_replay_block: assert property (st.state == tar_pkg::S_CHECK && st.seq <= ent.seq |=> // RQ18
    result_valid && !result_accept)
    else $error("replayed counter accepted");
  a_bad_sig: assert property (st.state == tar_pkg::S_CHECK && !st.sig_ok |-> // RQ26
    !mem_we ##1 result_valid && !result_accept)
    else $error("bad signature updated or accepted");
  a_try_all: assert property (result_valid && !result_resolved |-> // RQ10
    $past(st.idx, 2) == 3'(tar_pkg::NKEY - 1))
    else $error("gave up before the last key");

  c_learned: cover property (learn_valid && learn_en);
  c_priv_accept: cover property (result_valid && result_accept && st.priv_addr);
  c_replay: cover property (st.state == tar_pkg::S_CHECK && st.sig_ok && st.seq <= ent.seq);
  c_unresolved: cover property (result_valid && !result_resolved);

endmodule

//--- src/tar_pkg.sv
// Shared constants and types of the telegram authentication and address resolver.
// Assumes frames arrive as bytes starting at the frame control byte.
package tar_pkg;

  // ----------------------------------------------------------------
  // Frame layout, byte positions counted from frame control
  // ----------------------------------------------------------------
  localparam int FRAME_MAX = 41;           // Largest frame, commissioning
  localparam int HDR_BYTES = 2;            // Frame control and size byte
  localparam int CRC_BYTES = 3;            // Trailing check bytes
  localparam int ADDR_BYTES = 6;           // Source address size
  localparam int POS_LEN = 1;              // Source address + payload size
  localparam int POS_ADDR = 2;             // Source address, low byte first
  localparam int POS_PLEN = 8;             // Payload length byte
  localparam int POS_TYPE = 9;             // Payload type byte
  localparam int POS_MFR = 10;             // Manufacturer id, low byte first
  localparam int POS_SEQ = 12;             // Sequence counter, low byte first
  localparam int POS_KEY = 16;             // Commissioning security key
  localparam int POS_SADDR = 32;           // Commissioning static address
  localparam int SEQ_BYTES = 4;
  localparam int KEY_BYTES = 16;
  localparam int PLEN_EXTRA = 1;           // Length byte itself

  // ----------------------------------------------------------------
  // Field values
  // ----------------------------------------------------------------
  localparam logic [7:0] TYPE_MFR = 8'hFF;       // Manufacturer specific data
  localparam logic [7:0] PLEN_COMM = 8'h1D;      // Commissioning payload length
  localparam logic [7:0] PLEN_COMM_OLD = 8'h1E;  // Older transmitters
  localparam logic [7:0] ILEN_OFF = 8'h03;       // Input length = plen - 3
  localparam logic [7:0] ILEN0 = 8'h09;          // No optional data
  localparam logic [7:0] ILEN1 = 8'h0A;
  localparam logic [7:0] ILEN2 = 8'h0B;
  localparam logic [7:0] ILEN4 = 8'h0D;
  localparam int IDATA_MAX = 13;                 // Authenticated bytes bound
  localparam int SIG_BYTES = 4;
  localparam logic [7:0] FIRST_BLOCK_FLAG = 8'h49;
  localparam logic [7:0] CTR_BLOCK_FLAG = 8'h01;
  localparam logic [1:0] PRIV_MODE = 2'b01;       // Top two bits of a resolvable address

  // ----------------------------------------------------------------
  // Key store
  // ----------------------------------------------------------------
  localparam int NKEY = 8;
  localparam int KIDX_W = 3;

  typedef struct packed {
    logic valid;
    logic [127:0] key;    // identity_resolution_key, also security key
    logic [47:0] addr;    // Static source address
    logic [31:0] seq;     // Highest accepted sequence counter
  } tar_entry_t;

  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_RD = 9'h002,
    S_MATCH = 9'h004,
    S_HASH = 9'h008,
    S_A0 = 9'h010,
    S_X1 = 9'h020,
    S_X2 = 9'h040,
    S_CHECK = 9'h080,
    S_DONE = 9'h100
  } tar_state_t;

endpackage

//--- src/tar_key_mem.sv
// Small key store: one write port, one read port with registered data.
// Assumes the caller holds the read index to keep the data steady.
`timescale 1ns/1ps
module tar_key_mem (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic wr_en,
  input wire logic [tar_pkg::KIDX_W-1:0] wr_idx,
  input wire tar_pkg::tar_entry_t wr_data,
  input wire logic [tar_pkg::KIDX_W-1:0] rd_idx,
  output tar_pkg::tar_entry_t rd_data
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    tar_pkg::tar_entry_t [tar_pkg::NKEY-1:0] mem; // Slots
    tar_pkg::tar_entry_t rd;                      // Read register
  } tar_mem_t;

  tar_mem_t st;
  tar_mem_t next_st;

  // Write and read; a read of a slot being written returns old data
  always_comb
  begin
    next_st = st;
    next_st.rd = st.mem[rd_idx];
    if (wr_en)
    begin
      next_st.mem[wr_idx] = wr_data;
    end
  end

  // Reset empties every slot
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rd_data = st.rd;

endmodule

//--- src/tar_frame_parser.sv
// Collects one received frame into a byte buffer and flags its end.
// Assumes bytes come from logic on ref_clk, first byte marked by rx_start.
`timescale 1ns/1ps
module tar_frame_parser (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic rx_valid,
  input wire logic rx_start,
  input wire logic [7:0] rx_byte,
  output logic [tar_pkg::FRAME_MAX-1:0][7:0] frame,
  output logic frame_done
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [tar_pkg::FRAME_MAX-1:0][7:0] fbuf; // Frame bytes
    logic [5:0] cnt;                          // Bytes taken
    logic act;                                // Inside a frame
    logic done;                               // End pulse
  } tar_prs_t;

  tar_prs_t st;
  tar_prs_t next_st;
  logic [7:0] size_now;   // Size byte, live while it arrives
  logic [6:0] end_cnt;    // Total bytes of this frame

  always_comb
  begin
    size_now = (st.cnt == 6'(tar_pkg::POS_LEN)) ? rx_byte : st.fbuf[tar_pkg::POS_LEN];
    // Frame ends after header, address, payload and check bytes
    end_cnt = 7'(size_now) + 7'(tar_pkg::HDR_BYTES + tar_pkg::CRC_BYTES);  // RQ3 RQ5
  end

  // Byte capture; an oversize frame is dropped rather than truncated
  always_comb
  begin
    next_st = st;
    next_st.done = 1'b0;
    if (rx_valid && rx_start)
    begin
      next_st.fbuf[0] = rx_byte;
      next_st.cnt = 6'd1;
      next_st.act = 1'b1;
    end
    else if (rx_valid && st.act)
    begin
      next_st.fbuf[st.cnt] = rx_byte;
      next_st.cnt = st.cnt + 6'd1;
      if (st.cnt >= 6'(tar_pkg::POS_LEN) && 7'(st.cnt) + 7'd1 == end_cnt)
      begin
        next_st.act = 1'b0;
        next_st.done = 1'b1;  // RQ5
      end
      else if (st.cnt == 6'(tar_pkg::FRAME_MAX - 1))
      begin
        next_st.act = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign frame = st.fbuf;
  assign frame_done = st.done;

  // Done only when the byte count matches the size byte plus overhead
  a_frame_end: assert property (@(posedge ref_clk) disable iff (!rstn)
    frame_done |-> 7'(st.cnt) == 7'(st.fbuf[tar_pkg::POS_LEN]) + 7'd5)
    else $error("frame end not at size plus header and check bytes"); // RQ5

endmodule

//--- verification/tar_aes_model.sv
// Cipher partner for the resolver: answers each request lat + 1 cycles after it is raised.
// Assumes one ref_clk domain; a toy mix stands in for AES-128.
`timescale 1ns/1ps
module tar_aes_model (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [3:0] lat,
  input wire logic aes_req,
  input wire logic [127:0] aes_key,
  input wire logic [127:0] aes_din,
  output logic aes_ack,
  output logic [127:0] aes_dout
);
  logic [3:0] cnt; // Cycles waited on this request
  // ------------------------------------------------
  // Answer engine
  // ------------------------------------------------
  // Data toggles while idle and in the cycle after an ack so stale results never look valid
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt <= 4'h0;
      aes_ack <= 1'b0;
      aes_dout <= 128'h0;
    end
    else if (aes_ack || !aes_req)
    begin
      cnt <= 4'h0;
      aes_ack <= 1'b0;
      aes_dout <= ~aes_dout;
    end
    else if (cnt >= lat)
    begin
      aes_ack <= 1'b1;
      aes_dout <= aes_key ^ {aes_din[60:0], aes_din[127:61]};
    end
    else
      cnt <= cnt + 4'h1;
  end
endmodule

//--- verification/tar_resolver_tb.sv
// Bench for tar_resolver: learns keys, then sends data frames.
// Assumes tar_aes_model as the cipher partner.
`timescale 1ns/1ps
module tar_resolver_tb;
  localparam logic [15:0] MFR = 16'h5A5A; // Arbitrary maker id
  localparam logic [127:0] K0 = 128'h3C1F_9A02_7B48_70FD_2427_94F4_C452_20FB;
  localparam logic [127:0] K1 = 128'hAB4B_9A91_852B_70B8_A652_A05E_92BB_12A0;
  localparam logic [47:0] S0 = 48'hE215_0000_1B9F; // Static, not private
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic rx_valid = 1'b0;
  logic rx_start = 1'b0;
  logic [7:0] rx_byte = 8'h00;
  logic learn_en = 1'b0;
  logic [tar_pkg::KIDX_W-1:0] learn_slot = 3'h0;
  logic [3:0] lat = 4'h1; // Partner latency
  logic learn_valid, aes_req, aes_ack, result_valid, result_accept, result_resolved, busy;
  logic [31:0] learn_seq;
  logic [127:0] learn_key, aes_key, aes_din, aes_dout;
  logic [47:0] learn_addr;
  logic [tar_pkg::KIDX_W-1:0] result_slot;
  logic [7:0] fb [0:40]; // Frame bytes as sent
  int n_fail = 0;
  int total_checks = 0;
  tar_resolver #(.MFR_ID(MFR)) u_tar_resolver (.ref_clk, .rstn, .rx_valid, .rx_start,
    .rx_byte, .learn_en, .learn_slot, .learn_valid, .learn_seq, .learn_key, .learn_addr,
    .aes_req, .aes_key, .aes_din, .aes_ack, .aes_dout, .result_valid, .result_accept,
    .result_resolved, .result_slot, .busy);
  tar_aes_model u_tar_aes_model (.ref_clk, .rstn, .lat, .aes_req, .aes_key, .aes_din,
    .aes_ack, .aes_dout);
  initial
    forever #2 ref_clk = ~ref_clk;
  // Same toy mix as the partner
  function automatic logic [127:0] f(logic [127:0] k, logic [127:0] d);
    return k ^ {d[60:0], d[127:61]};
  endfunction
  task automatic chk(logic [127:0] got, logic [127:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Little or big endian byte fill
  task automatic put(int p, int n, logic [127:0] v, bit le);
    for (int i = 0; i < n; i++)
      fb[p+i] = le ? v[8*i +: 8] : v[8*(n-1-i) +: 8];
  endtask
  task automatic send(int n);
    for (int i = 0; i < n; i++)
    begin
      @(negedge ref_clk);
      rx_valid = 1'b1;
      rx_start = (i == 0);
      rx_byte = fb[i];
    end
    @(negedge ref_clk);
    rx_valid = 1'b0;
  endtask
  task automatic learn(logic [2:0] s, logic [127:0] k, logic [31:0] q, logic [7:0] pl);
    put(0, 2, 16'h2442, 1);
    put(2, 6, S0, 1);
    put(8, 4, {MFR, 8'hFF, pl}, 1);
    put(12, 4, q, 1);
    put(16, 16, k, 0);
    put(32, 6, S0 ^ s, 1);
    put(38, 3, 24'hA5C3E1, 1);
    learn_slot = s;
    learn_en = 1'b1;
    send(41);
    for (int i = 0; i < 50 && !learn_valid; i++) @(negedge ref_clk);
    chk(learn_valid, 1'b1);
    chk(learn_seq, q);
    chk(learn_key, k);
    chk(learn_addr, S0 ^ s);
    learn_en = 1'b0;
  endtask
  task automatic data(logic [47:0] a, logic [127:0] k, logic [31:0] q, logic bad,
    logic ac, logic rs, logic [2:0] sl);
    logic [127:0] a0, t;
    put(0, 2, 16'h1342, 1);
    put(2, 6, a, 1);
    put(8, 4, {MFR, 16'hFF0C}, 1);
    put(12, 4, q, 1);
    fb[16] = 8'h10;
    a0 = {8'h01, fb[2], fb[3], fb[4], fb[5], fb[6], fb[7], fb[12], fb[13], fb[14], fb[15], 40'h0};
    t = f(k, a0) ^ f(k, f(k, a0 ^ {8'h48, 120'h0}) ^ {16'h0009, fb[8], fb[9], fb[10], fb[11],
      fb[12], fb[13], fb[14], fb[15], fb[16], 40'h0});
    put(17, 4, t[127:96] ^ bad, 0);
    put(21, 3, 24'h23EE16, 1);
    send(24);
    @(negedge ref_clk);
    chk(busy, 1'b1);
    for (int i = 0; i < 300 && !result_valid; i++) @(negedge ref_clk);
    chk(result_valid, 1'b1);
    chk(result_accept, ac);
    chk(result_resolved, rs);
    if (rs)
      chk(result_slot, sl);
  endtask
  task automatic t_learn;
    learn(0, K0, 32'h171, 8'h1E);
    learn(1, K1, 32'h10, 8'h1D);
    $display("test learn done");
  endtask
  task automatic t_replay;
    data(S0, K0, 32'h172, 0, 1, 1, 0);
    data(S0, K0, 32'h172, 0, 0, 1, 0);
    $display("test replay done");
  endtask
  task automatic t_badsig;
    data(S0, K0, 32'h180, 1, 0, 1, 0);
    lat = 4'h5;
    data(S0, K0, 32'h173, 0, 1, 1, 0);
    $display("test badsig done");
  endtask
  task automatic t_priv;
    logic [23:0] h;
    h = 24'(f(K1, {104'h0, 24'h493970}));
    data({24'h493970, h}, K1, 32'h11, 0, 1, 1, 1);
    data({24'h493970, ~h}, K1, 32'h12, 0, 0, 0, 0);
    $display("test private done");
  endtask
  task automatic summarize;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(negedge ref_clk);
    rstn = 1'b1;
    t_learn;
    t_replay;
    t_badsig;
    t_priv;
    summarize;
  end
  // Whole run needs well under 2000 cycles
  initial
  begin
    #20000;
    n_fail++;
    summarize;
  end
endmodule
